// file: pkg/awt_pkg.sv
`default_nettype none
package awt_pkg;
    // table geometry: eight channels, five-bit sample index
    localparam int          AWT_NCH          = 8;
    localparam int          AWT_NIDX         = 32;
    // register indices, byte address is four times the index
    localparam logic [5:0]  AWT_IDX_STATUS   = 6'h13;
    localparam logic [5:0]  AWT_IDX_IEN      = 6'h14;
    localparam logic [5:0]  AWT_IDX_FLAGS    = 6'h15;
    localparam logic [5:0]  AWT_IDX_BMASK    = 6'h16;
    localparam logic [5:0]  AWT_IDX_PTR      = 6'h17;
    localparam logic [5:0]  AWT_IDX_WIN      = 6'h18;
    // reset values
    localparam logic [7:0]  AWT_RST_IEN      = 8'h00;
    localparam logic [7:0]  AWT_RST_FLAGS    = 8'h00;
    localparam logic [7:0]  AWT_RST_BMASK    = 8'h00;
    localparam logic [7:0]  AWT_RST_PTR      = 8'h00;
    // pointer fields: channel in [7:5], sample index in [4:0]
    localparam int          AWT_PTR_CH_LSB   = 5;
    localparam int          AWT_PTR_CH_MSB   = 7;
    localparam int          AWT_PTR_IDX_MSB  = 4;
    // axi responses
    localparam logic [1:0]  AWT_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  AWT_RESP_SLVERR  = 2'h2;
    // one phase sample, two's complement
    typedef logic signed [6:0] awt_sample_t;
    localparam awt_sample_t AWT_SAMPLE_RST   = 7'h00;
    typedef logic [2:0]        awt_ch_t;
    typedef logic [4:0]        awt_idx_t;
endpackage
`default_nettype wire

// file: pkg/awt_tbl_if.sv
`timescale 1ns/1ns
`default_nettype none
interface awt_tbl_if;
    import awt_pkg::*;
    logic        wr_en;
    logic [7:0]  wr_mask;
    awt_ch_t     wr_ch;
    awt_idx_t    wr_idx;
    awt_sample_t wr_data;
    awt_ch_t     rd_ch;
    awt_idx_t    rd_idx;
    awt_sample_t rd_data;
    modport ctrl  (output wr_en, wr_mask, wr_ch, wr_idx, wr_data,
                   output rd_ch, rd_idx, input rd_data);
    modport store (input wr_en, wr_mask, wr_ch, wr_idx, wr_data,
                   input rd_ch, rd_idx, output rd_data);
endinterface
`default_nettype wire

// file: logic/awt_alarm_flags.sv
`timescale 1ns/1ns
`default_nettype none
module awt_alarm_flags
    import awt_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       soft_clr,
    input  wire logic [7:0] alarm_status,
    input  wire logic [7:0] enable,
    input  wire logic       clr_rd,
    input  wire logic [7:0] clr_w1c,
    output logic      [7:0] flags
);
    typedef struct packed {
        logic [7:0] prev;
        logic [7:0] flags;
    } awt_af_t;

    awt_af_t    st_ff;
    awt_af_t    nxt_st;
    logic [7:0] set_v;
    logic [7:0] clr_v;

    // an enabled edge on any alarm bit marks that channel
    assign set_v = (alarm_status ^ st_ff.prev) & enable;
    assign clr_v = (clr_rd || soft_clr) ? 8'hff : clr_w1c;

    // set beats clear so a change in the clearing cycle is kept
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.prev  = alarm_status;
        nxt_st.flags = (st_ff.flags & ~clr_v) | set_v;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{prev: 8'h00, flags: AWT_RST_FLAGS};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flags = st_ff.flags;

    property p_flag_set;
        @(posedge ref_clk) disable iff (rst)
        (set_v != 8'h00) |=> ((flags & $past(set_v)) == $past(set_v));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("alarm change not recorded");

    property p_flag_hold;
        @(posedge ref_clk) disable iff (rst)
        (!clr_rd && !soft_clr && clr_w1c == 8'h00)
            |=> ((flags & $past(flags)) == $past(flags));
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("change flag dropped without a clear");

    property p_rd_clear;
        @(posedge ref_clk) disable iff (rst)
        clr_rd |=> (flags == $past(set_v));
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("flag read did not clear");
endmodule
`default_nettype wire

// file: logic/awt_wave_table.sv
`timescale 1ns/1ns
`default_nettype none
module awt_wave_table
    import awt_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    awt_tbl_if.store  tb
);
    typedef struct packed {
        awt_sample_t [AWT_NCH-1:0][AWT_NIDX-1:0] mem;
    } awt_tbl_t;

    awt_tbl_t st_ff;
    awt_tbl_t nxt_st;

    // every selected channel takes the sample in the same cycle
    always_comb begin
        nxt_st = st_ff;
        for (int c = 0; c < AWT_NCH; c++) begin
            if (tb.wr_en && tb.wr_mask[c]) begin
                nxt_st.mem[c][tb.wr_idx] = tb.wr_data;
            end
        end
    end

    // only the power-up reset reaches the table; soft reset never does
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tb.rd_data = st_ff.mem[tb.rd_ch][tb.rd_idx];

    property p_bcast_ch0;
        @(posedge ref_clk) disable iff (rst)
        (tb.wr_en && tb.wr_mask[0])
            |=> (st_ff.mem[0][$past(tb.wr_idx)] == $past(tb.wr_data));
    endproperty
    a_bcast_ch0: assert property (p_bcast_ch0)
        else $error("masked channel zero not written");
endmodule
`default_nettype wire

// file: logic/awt_top.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - enabled alarm change sets flag, raises interrupt
// - flag bit n marks channel n change
// - flags accumulate until next clear
// - four control registers clear on any reset
// - broadcast mask writes data to selected channels
// - pointer bits 7..5 pick the channel
// - pointer bits 4..0 pick the sample
// - data writes store, reads return addressed sample
// - soft reset keeps table contents
// - samples are signed seven bit values
// - table holds zero after power-up
// - reading flag register clears interrupt
// - status bit n shows channel n alarm
// - enable gates interrupts, not live status
module awt_top
    import awt_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              soft_rst,
    input  wire logic [7:0]        alarm_status,
    output logic                   irq_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    typedef struct packed {
        logic        aw_rdy;
        logic        w_rdy;
        logic        ar_rdy;
        logic        bvalid;
        logic        rvalid;
        logic [1:0]  bresp;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_have;
        logic        w_have;
        logic [5:0]  waddr;
        logic [7:0]  wdata;
        logic        wstrb0;
        logic [7:0]  ien;
        logic [7:0]  bmask;
        logic [7:0]  ptr;
        logic        irq_n;
    } awt_regs_t;

    awt_regs_t  st_ff;
    awt_regs_t  nxt_st;
    logic       do_wr;
    logic       aw_hs;
    logic       w_hs;
    logic       ar_hs;
    logic [5:0] ar_idx;
    logic       clr_rd;
    logic [7:0] clr_w1c;
    logic [7:0] flags;
    logic       wr_ok;

    awt_tbl_if tbl ();

    // protection bits carry no meaning for this register bank
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1],
                           s_axi_wdata[31:8]};

    // index decode: every register is one aligned word
    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx >= AWT_IDX_STATUS) && (idx <= AWT_IDX_WIN);
    endfunction

    // handshakes and the moment both halves of a write are held
    assign aw_hs  = s_axi_awvalid && st_ff.aw_rdy;
    assign w_hs   = s_axi_wvalid && st_ff.w_rdy;
    assign ar_hs  = s_axi_arvalid && st_ff.ar_rdy;
    assign ar_idx = s_axi_araddr[7:2];
    assign do_wr  = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    // low byte lane must be enabled for a register to change
    assign wr_ok  = do_wr && st_ff.wstrb0;

    // reading the flag register clears it as a side effect
    assign clr_rd  = ar_hs && (ar_idx == AWT_IDX_FLAGS);
    // write-one-to-clear path for the same flags
    assign clr_w1c = (wr_ok && st_ff.waddr == AWT_IDX_FLAGS)
                     ? st_ff.wdata : 8'h00;

    awt_alarm_flags u_flags (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .soft_clr     (soft_rst),
        .alarm_status (alarm_status),
        .enable       (st_ff.ien),
        .clr_rd       (clr_rd),
        .clr_w1c      (clr_w1c),
        .flags        (flags)
    );

    // table port: pointer addresses reads and single-channel writes
    assign tbl.rd_ch   = st_ff.ptr[AWT_PTR_CH_MSB:AWT_PTR_CH_LSB];
    assign tbl.rd_idx  = st_ff.ptr[AWT_PTR_IDX_MSB:0];
    assign tbl.wr_ch   = tbl.rd_ch;
    assign tbl.wr_idx  = tbl.rd_idx;
    assign tbl.wr_data = st_ff.wdata[6:0];
    assign tbl.wr_en   = wr_ok && (st_ff.waddr == AWT_IDX_WIN);
    // zero mask falls back to the pointed channel only
    assign tbl.wr_mask = (st_ff.bmask == 8'h00)
                         ? 8'(8'h01 << tbl.wr_ch)
                         : st_ff.bmask;

    awt_wave_table u_table (
        .ref_clk (ref_clk),
        .rst     (rst),
        .tb      (tbl.store)
    );

    // read mux; bit 7 of the data window always reads zero
    function automatic logic [31:0] rd_mux(input logic [5:0] idx,
                                           input awt_regs_t  s,
                                           input logic [7:0] fl,
                                           input logic [7:0] al,
                                           input awt_sample_t sm);
        case (idx)
            AWT_IDX_STATUS: rd_mux = {24'h000000, al};
            AWT_IDX_IEN:    rd_mux = {24'h000000, s.ien};
            AWT_IDX_FLAGS:  rd_mux = {24'h000000, fl};
            AWT_IDX_BMASK:  rd_mux = {24'h000000, s.bmask};
            AWT_IDX_PTR:    rd_mux = {24'h000000, s.ptr};
            AWT_IDX_WIN:    rd_mux = {25'h0000000, sm};
            default:        rd_mux = 32'h00000000;
        endcase
    endfunction

    // bus slave, control registers and interrupt pin in one step
    always_comb begin
        nxt_st = st_ff;
        // write address and data are taken in either order
        if (aw_hs) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.waddr   = s_axi_awaddr[7:2];
        end
        if (w_hs) begin
            nxt_st.w_have = 1'b1;
            nxt_st.wdata  = s_axi_wdata[7:0];
            nxt_st.wstrb0 = s_axi_wstrb[0];
        end
        if (do_wr) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = is_mapped(st_ff.waddr) ? AWT_RESP_OKAY
                                                    : AWT_RESP_SLVERR;
            if (st_ff.wstrb0) begin
                case (st_ff.waddr)
                    AWT_IDX_IEN:   nxt_st.ien   = st_ff.wdata;
                    AWT_IDX_BMASK: nxt_st.bmask = st_ff.wdata;
                    AWT_IDX_PTR:   nxt_st.ptr   = st_ff.wdata;
                    default:       nxt_st.ien   = nxt_st.ien;
                endcase
            end
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // one write in flight: no new halves until the answer leaves
        nxt_st.aw_rdy = !nxt_st.aw_have && !nxt_st.bvalid;
        nxt_st.w_rdy  = !nxt_st.w_have && !nxt_st.bvalid;
        // read path answers one cycle after the address is taken
        if (ar_hs) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = rd_mux(ar_idx, st_ff, flags, alarm_status,
                                   tbl.rd_data);
            nxt_st.rresp  = is_mapped(ar_idx) ? AWT_RESP_OKAY
                                              : AWT_RESP_SLVERR;
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        nxt_st.ar_rdy = !nxt_st.rvalid;
        // soft reset clears control state but leaves the bus alone
        if (soft_rst) begin
            nxt_st.ien   = AWT_RST_IEN;
            nxt_st.bmask = AWT_RST_BMASK;
            nxt_st.ptr   = AWT_RST_PTR;
        end
        // flagged and enabled channels pull the pin low
        nxt_st.irq_n = ~|(flags & st_ff.ien);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff       <= '0;
            st_ff.irq_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // every output straight from the state register
    assign s_axi_awready = st_ff.aw_rdy;
    assign s_axi_wready  = st_ff.w_rdy;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = st_ff.ar_rdy;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
    assign irq_n         = st_ff.irq_n;

    // checks on the block's own outputs and internal state
    sequence s_wr_pair;
        st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    endsequence

    sequence s_b_stall;
        s_axi_bvalid && !s_axi_bready;
    endsequence

    sequence s_win_read;
        ar_hs && (ar_idx == AWT_IDX_WIN);
    endsequence

    property p_write_resp;
        @(posedge ref_clk) disable iff (rst)
        s_wr_pair |=> s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write answer missing");

    property p_b_hold;
        @(posedge ref_clk) disable iff (rst)
        s_b_stall |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write answer dropped before taken");

    property p_irq;
        @(posedge ref_clk) disable iff (rst)
        ##1 (irq_n == !$past(|(flags & st_ff.ien)));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt pin disagrees with flags");

    property p_soft_clear;
        @(posedge ref_clk) disable iff (rst)
        soft_rst |=> (st_ff.ien == 8'h00) && (st_ff.bmask == 8'h00)
                     && (st_ff.ptr == 8'h00);
    endproperty
    a_soft_clear: assert property (p_soft_clear)
        else $error("soft reset left a register set");

    property p_win_read;
        @(posedge ref_clk) disable iff (rst)
        s_win_read |=> s_axi_rvalid
                       && (s_axi_rdata[6:0] == $past(tbl.rd_data))
                       && (s_axi_rdata[31:7] == 25'h0000000);
    endproperty
    a_win_read: assert property (p_win_read)
        else $error("data window read wrong sample");

    property p_ptr_split;
        @(posedge ref_clk) disable iff (rst)
        (wr_ok && st_ff.waddr == AWT_IDX_PTR && !soft_rst)
            |=> (tbl.rd_ch == $past(st_ff.wdata[7:5]))
                && (tbl.rd_idx == $past(st_ff.wdata[4:0]));
    endproperty
    a_ptr_split: assert property (p_ptr_split)
        else $error("pointer fields misrouted");

    property p_single_wr;
        @(posedge ref_clk) disable iff (rst)
        (tbl.wr_en && st_ff.bmask == 8'h00)
            |-> ($countones(tbl.wr_mask) == 1);
    endproperty
    a_single_wr: assert property (p_single_wr)
        else $error("zero mask wrote more than one channel");

    property p_status_live;
        @(posedge ref_clk) disable iff (rst)
        (ar_hs && ar_idx == AWT_IDX_STATUS)
            |=> (s_axi_rdata[7:0] == $past(alarm_status));
    endproperty
    a_status_live: assert property (p_status_live)
        else $error("status read not live alarm level");

    // a stalled read answer must not change under the master
    sequence s_r_stall;
        s_axi_rvalid && !s_axi_rready;
    endsequence

    property p_r_hold;
        @(posedge ref_clk) disable iff (rst)
        s_r_stall |=> s_axi_rvalid && $stable(s_axi_rdata)
                      && $stable(s_axi_rresp);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read answer dropped before taken");

    // only one read in flight, so no address while an answer waits
    property p_ar_refuse;
        @(posedge ref_clk) disable iff (rst)
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_refuse: assert property (p_ar_refuse)
        else $error("read address taken while answer pending");

    // a flag read with no fresh change frees the pin two edges on
    property p_rd_release;
        @(posedge ref_clk) disable iff (rst)
        (clr_rd && (alarm_status == $past(alarm_status))) |-> ##2 irq_n;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("flag read left the interrupt asserted");

    // soft reset may clear control state but never the samples
    property p_soft_keep;
        @(posedge ref_clk) disable iff (rst)
        (soft_rst && !tbl.wr_en) |=> $stable(u_table.st_ff);
    endproperty
    a_soft_keep: assert property (p_soft_keep)
        else $error("soft reset disturbed the wave table");

    // zero-mask write must be readable at the pointer next cycle
    property p_win_write;
        @(posedge ref_clk) disable iff (rst)
        (tbl.wr_en && st_ff.bmask == 8'h00 && !soft_rst)
            |=> (tbl.rd_data == $past(tbl.wr_data));
    endproperty
    a_win_write: assert property (p_win_write)
        else $error("pointed sample not written");
endmodule
`default_nettype wire

// file: verification/awt_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin \
    compares++; \
    if ((got) !== (ex)) begin \
        errors++; \
        $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end \
end
module awt_top_tb_top;
    import awt_pkg::*;
    logic        ref_clk, rst, soft_rst, irq_n;
    logic [7:0]  alarm_status, s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, r;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] exp_q[$];
    logic [33:0] mon_ex;
    string       nm_q[$];
    string       mon_nm;
    logic [6:0]  tbl[8][32];
    logic [7:0]  a0, en, acc, tog, bm;
    logic [6:0]  d;
    logic [4:0]  ix;
    int          errors;
    int          compares;

    awt_top #(.ADDR_W(8)) i_dut (
        .ref_clk, .rst, .soft_rst, .alarm_status, .irq_n,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    // free-running 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // scoreboard: every b or r handshake retires the oldest note
    always @(posedge ref_clk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("MISMATCH response with no expectation");
            end else begin
                mon_ex = exp_q.pop_front();
                mon_nm = nm_q.pop_front();
                if (s_axi_bvalid && s_axi_bready)
                    `CHK(mon_nm, mon_ex, {s_axi_bresp, 32'h0})
                else
                    `CHK(mon_nm, mon_ex, {s_axi_rresp, s_axi_rdata})
            end
        end
    end

    // waits an edge first so no signal is assigned twice in one step
    task automatic wr(input logic [5:0] i, input logic [7:0] v,
                      input logic [3:0] st, input logic [1:0] rs);
        logic [31:0] up;
        @(posedge ref_clk);
        up = xs();
        exp_q.push_back({rs, 32'h0});
        nm_q.push_back($sformatf("bresp idx %h", i));
        s_axi_awaddr  <= {i, 2'b00};
        s_axi_wdata   <= {up[31:8], v};   // upper bits ignored
        s_axi_wstrb   <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask

    task automatic wo(input logic [5:0] i, input logic [7:0] v);
        wr(i, v, 4'hf, AWT_RESP_OKAY);
    endtask

    task automatic rd(input logic [5:0] i, input logic [7:0] v,
                      input logic [1:0] rs);
        @(posedge ref_clk);
        exp_q.push_back({rs, 24'h0, v});
        nm_q.push_back($sformatf("rdata idx %h", i));
        s_axi_araddr  <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask

    // irq is registered two edges after its cause, four leaves margin
    task automatic irq_chk(input logic ex_n);
        repeat (4) @(posedge ref_clk);
        `CHK("irq_n", ex_n, irq_n)
    endtask

    task automatic alarm(input logic [7:0] t);
        @(posedge ref_clk);
        alarm_status <= a0 ^ t;
        acc |= t & en;
        a0 ^= t;
    endtask

    // hang guard, far above the expected thousand or so cycles
    initial begin
        repeat (40000) @(posedge ref_clk);
        errors++;
        $display("MISMATCH watchdog expired");
        tally_and_finish();
    end

    initial begin
        seed = 32'h2b71;
        errors = 0;
        compares = 0;
        {rst, soft_rst, alarm_status} = {1'b1, 1'b0, 8'h00};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        foreach (tbl[c, x]) tbl[c][x] = 7'h00;
        {a0, en, acc} = '0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;

        rd(AWT_IDX_IEN, 8'h00, AWT_RESP_OKAY);
        rd(AWT_IDX_FLAGS, 8'h00, AWT_RESP_OKAY);
        rd(AWT_IDX_BMASK, 8'h00, AWT_RESP_OKAY);
        rd(AWT_IDX_PTR, 8'h00, AWT_RESP_OKAY);
        rd(AWT_IDX_WIN, 8'h00, AWT_RESP_OKAY);
        rd(6'h00, 8'h00, AWT_RESP_SLVERR);
        wr(6'h3f, 8'h5a, 4'hf, AWT_RESP_SLVERR);
        $display("test reset_values done");

        // status is live even with every enable clear
        alarm(8'(xs()));
        irq_chk(1'b1);
        rd(AWT_IDX_STATUS, a0, AWT_RESP_OKAY);
        rd(AWT_IDX_FLAGS, 8'h00, AWT_RESP_OKAY);
        r = xs();
        en = r[7:0] | 8'h01;
        wo(AWT_IDX_IEN, en);
        rd(AWT_IDX_IEN, en, AWT_RESP_OKAY);
        alarm(r[15:8] | 8'h01);
        irq_chk(1'b0);
        alarm(r[23:16]);
        rd(AWT_IDX_STATUS, a0, AWT_RESP_OKAY);
        bm = acc & r[31:24];
        wo(AWT_IDX_FLAGS, bm);
        acc &= ~bm;
        irq_chk(acc == 8'h00);
        rd(AWT_IDX_FLAGS, acc, AWT_RESP_OKAY);
        acc = 8'h00;
        irq_chk(1'b1);
        rd(AWT_IDX_FLAGS, 8'h00, AWT_RESP_OKAY);
        alarm(~en);
        irq_chk(1'b1);
        rd(AWT_IDX_FLAGS, 8'h00, AWT_RESP_OKAY);
        $display("test alarm_interrupt done");

        // software reset clears control state but keeps the table
        wo(AWT_IDX_PTR, {3'd5, 5'd9});
        wo(AWT_IDX_WIN, 8'h2a);
        tbl[5][9] = 7'h2a;
        wo(AWT_IDX_BMASK, 8'hff);
        alarm(8'h01);
        irq_chk(1'b0);
        @(posedge ref_clk);
        soft_rst <= 1'b1;
        @(posedge ref_clk);
        soft_rst <= 1'b0;
        acc = 8'h00;
        en = 8'h00;
        irq_chk(1'b1);
        rd(AWT_IDX_IEN, 8'h00, AWT_RESP_OKAY);
        rd(AWT_IDX_FLAGS, 8'h00, AWT_RESP_OKAY);
        rd(AWT_IDX_BMASK, 8'h00, AWT_RESP_OKAY);
        rd(AWT_IDX_PTR, 8'h00, AWT_RESP_OKAY);
        wo(AWT_IDX_PTR, {3'd5, 5'd9});
        rd(AWT_IDX_WIN, 8'h2a, AWT_RESP_OKAY);
        $display("test soft_reset done");

        // random broadcast and single-channel writes, each sample read back on all channels
        for (int k = 0; k < 12; k++) begin
            r = xs();
            // keep the sample index in the range 0 to 23
            ix = 5'(r[4:0] % 24);
            bm = (k % 3 == 0) ? 8'h00 : r[15:8];
            d = (k == 0) ? 7'h3f : (k == 1) ? 7'h40 : r[22:16];
            wo(AWT_IDX_BMASK, bm);
            wo(AWT_IDX_PTR, {r[7:5], ix});
            rd(AWT_IDX_PTR, {r[7:5], ix}, AWT_RESP_OKAY);
            wo(AWT_IDX_WIN, {1'b0, d});
            for (int c = 0; c < 8; c++)
                if (bm == 8'h00 ? c == r[7:5] : bm[c])
                    tbl[c][ix] = d;
            for (int c = 0; c < 8; c++) begin
                wo(AWT_IDX_PTR, {c[2:0], ix});
                rd(AWT_IDX_WIN, {1'b0, tbl[c][ix]},
                   AWT_RESP_OKAY);
            end
        end
        // a write without its low byte lane leaves the sample alone
        wr(AWT_IDX_WIN, 8'h11, 4'he, AWT_RESP_OKAY);
        rd(AWT_IDX_WIN, {1'b0, tbl[7][ix]}, AWT_RESP_OKAY);
        $display("test wave_table done");

        // power-up reset in mid-run empties the table
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        for (int c = 0; c < 8; c++) begin
            wo(AWT_IDX_PTR, {c[2:0], ix});
            rd(AWT_IDX_WIN, 8'h00, AWT_RESP_OKAY);
        end
        $display("test power_up_reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
